// ---- src/ptab_timebase.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptab_timebase (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // generator b side
  input wire logic reload_flag_b,
  input wire logic loaded_b,
  output logic generator_b_enable,
  output logic load_ok_b,
  output logic irq_b,
  // generator a timebase
  output logic generator_a_enable,
  output logic load_ok_a,
  output logic pwm_tick_a,
  output logic reload_a,
  output logic [14:0] counter_a,
  output logic [14:0] period_a_active,
  output logic [1:0] divider_sel_a_active,
  output logic [14:0] dead_bus_cycles_a,
  output logic irq_a
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] div_of(input logic [1:0] sel);
    return 4'h1 << sel;
  endfunction : div_of

  function automatic logic [14:0] dead_cycles(input logic [1:0] sel, input logic [11:0] val);
    logic [14:0] prod;
    prod = 15'({3'h0, val} << sel);
    return (sel == 2'h0) ? prod : 15'(prod - 15'h0001);
  endfunction : dead_cycles

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff;
  logic [3:0] interval_buf_ff, interval_act_ff;
  logic half_ff;
  logic [1:0] div_buf_ff, div_act_ff;
  logic flag_a_ff, nxt_flag_a, flag_armed_ff;
  logic [14:0] period_buf_ff, period_act_ff;
  logic [11:0] dead_ff;
  logic en_a_ff, ldok_a_ff, nxt_ldok_a, ldok_a_armed_ff, irqen_a_ff;
  logic en_b_ff, ldok_b_ff, nxt_ldok_b, ldok_b_armed_ff, irqen_b_ff;
  logic mode_ff, center_ff, wprot_ff;
  logic [2:0] div_cnt_ff;
  logic tick_ff, reload_ff;
  logic [14:0] cnt_ff, nxt_cnt;
  ptab_pkg::ptab_dir_t dir_ff, nxt_dir;
  logic [3:0] opp_cnt_ff;
  logic irq_a_ff, irq_b_ff;
  logic [14:0] dead_out_ff;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic [5:0] idx = paddr[7:2];
  wire logic aligned = (paddr[1:0] == 2'h0);
  wire logic sel_en_a = aligned && (idx == ptab_pkg::IDX_ENABLE_A);
  wire logic sel_freq = aligned && (idx == ptab_pkg::IDX_FREQ_A);
  wire logic sel_cnt = aligned && (idx == ptab_pkg::IDX_COUNTER_A);
  wire logic sel_per = aligned && (idx == ptab_pkg::IDX_PERIOD_A);
  wire logic sel_dead = aligned && (idx == ptab_pkg::IDX_DEAD_A);
  wire logic sel_en_b = aligned && (idx == ptab_pkg::IDX_ENABLE_B);
  wire logic sel_cfg = aligned && (idx == ptab_pkg::IDX_CONFIG);
  wire logic mapped = sel_en_a | sel_freq | sel_cnt | sel_per | sel_dead | sel_en_b | sel_cfg;
  // access completes at the edge where pready is seen high
  wire logic done = psel && penable && pready_ff;
  wire logic wr = done && pwrite && mapped;
  wire logic rd = done && !pwrite && mapped;
  wire logic [7:0] freq_rd = {interval_buf_ff, half_ff, div_buf_ff, flag_a_ff};
  wire logic [7:0] en_a_rd = {en_a_ff, 5'h00, ldok_a_ff, irqen_a_ff};
  wire logic [7:0] en_b_rd = {en_b_ff, 5'h00, ldok_b_ff, irqen_b_ff};
  wire logic [7:0] cfg_rd = {5'h00, wprot_ff, center_ff, mode_ff};
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (sel_en_a) begin
      nxt_prdata = {24'h000000, en_a_rd};
    end else if (sel_freq) begin
      nxt_prdata = {24'h000000, freq_rd};
    end else if (sel_cnt) begin
      nxt_prdata = {17'h00000, cnt_ff};
    end else if (sel_per) begin
      nxt_prdata = {17'h00000, period_buf_ff};
    end else if (sel_dead) begin
      nxt_prdata = {20'h00000, dead_ff};
    end else if (sel_en_b) begin
      nxt_prdata = {24'h000000, en_b_rd};
    end else if (sel_cfg) begin
      nxt_prdata = {24'h000000, cfg_rd};
    end
  end

  // ----------------------------------------------------------------
  // apb handshake, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (psel && penable && !pready_ff && !pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  wire logic [2:0] div_last = 3'(div_of(div_act_ff) - 4'h1);
  wire logic tick = (div_cnt_ff >= div_last);
  wire logic [14:0] per_top = 15'(period_act_ff - 15'h0001);
  logic full_opp, half_opp;
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    full_opp = 1'b0;
    half_opp = 1'b0;
    if (tick && en_a_ff) begin
      if (!center_ff) begin
        if (cnt_ff >= per_top) begin
          nxt_cnt = 15'h0000;
          full_opp = 1'b1;
        end else begin
          nxt_cnt = 15'(cnt_ff + 15'h0001);
        end
      end else begin
        case (dir_ff)
          ptab_pkg::PTAB_UP: begin
            if (cnt_ff >= per_top) begin
              nxt_dir = ptab_pkg::PTAB_DOWN;
              half_opp = half_ff;
            end else begin
              nxt_cnt = 15'(cnt_ff + 15'h0001);
            end
          end
          ptab_pkg::PTAB_DOWN: begin
            if (cnt_ff == 15'h0000) begin
              nxt_dir = ptab_pkg::PTAB_UP;
              full_opp = 1'b1;
            end else begin
              nxt_cnt = 15'(cnt_ff - 15'h0001);
            end
          end
          default: begin
            nxt_dir = ptab_pkg::PTAB_UP;
          end
        endcase
      end
    end
  end
  wire logic opp = full_opp | half_opp;
  wire logic reload = opp && (opp_cnt_ff >= interval_act_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 3'h0;
      cnt_ff <= 15'h0000;
      dir_ff <= ptab_pkg::PTAB_UP;
      opp_cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
      reload_ff <= 1'b0;
    end else begin
      div_cnt_ff <= tick ? 3'h0 : 3'(div_cnt_ff + 3'h1);
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
      tick_ff <= tick && en_a_ff;
      reload_ff <= reload;
      if (reload) begin
        opp_cnt_ff <= 4'h0;
      end else if (opp) begin
        opp_cnt_ff <= 4'(opp_cnt_ff + 4'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // frequency control a and buffered values
  // ----------------------------------------------------------------
  wire logic wr_freq = wr && sel_freq;
  wire logic wr_flag_one = wr_freq && pwdata[ptab_pkg::RELOAD_FLAG_BIT];
  always_comb begin
    nxt_flag_a = flag_a_ff;
    if (wr_flag_one && flag_armed_ff) begin
      nxt_flag_a = 1'b0;
    end
    if (reload) begin
      nxt_flag_a = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_buf_ff <= ptab_pkg::INTERVAL_RST;
      interval_act_ff <= ptab_pkg::INTERVAL_RST;
      half_ff <= 1'b0;
      div_buf_ff <= ptab_pkg::DIVIDER_RST;
      div_act_ff <= ptab_pkg::DIVIDER_RST;
      period_buf_ff <= ptab_pkg::PERIOD_RST;
      period_act_ff <= ptab_pkg::PERIOD_RST;
      flag_a_ff <= 1'b0;
      flag_armed_ff <= 1'b0;
    end else begin
      flag_a_ff <= nxt_flag_a;
      if (reload || wr_freq) begin
        flag_armed_ff <= 1'b0;
      end else if (rd && sel_freq && flag_a_ff) begin
        flag_armed_ff <= 1'b1;
      end
      if (wr_freq) begin
        interval_buf_ff <= pwdata[ptab_pkg::RELOAD_INTERVAL_LSB +: 4];
        half_ff <= pwdata[ptab_pkg::HALF_RELOAD_BIT];
        div_buf_ff <= pwdata[ptab_pkg::DIVIDER_SEL_LSB +: 2];
      end
      if (wr && sel_per) begin
        period_buf_ff <= pwdata[14:0];
      end
      if (reload) begin
        interval_act_ff <= interval_buf_ff;
      end
      if (reload && ldok_a_ff) begin
        div_act_ff <= div_buf_ff;
        period_act_ff <= period_buf_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable control a, dead time, configuration
  // ----------------------------------------------------------------
  wire logic wr_en_a = wr && sel_en_a;

  always_comb begin
    nxt_ldok_a = ldok_a_ff;
    if (reload && ldok_a_ff) begin
      nxt_ldok_a = 1'b0;
    end
    if (wr_en_a) begin
      if (!pwdata[ptab_pkg::LOAD_OK_BIT]) begin
        nxt_ldok_a = 1'b0;
      end else if (ldok_a_armed_ff || ldok_a_ff) begin
        nxt_ldok_a = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_a_ff <= 1'b0;
      ldok_a_ff <= 1'b0;
      ldok_a_armed_ff <= 1'b0;
      irqen_a_ff <= 1'b0;
      dead_ff <= ptab_pkg::DEAD_TIME_RST;
      mode_ff <= 1'b0;
      center_ff <= 1'b0;
      wprot_ff <= 1'b0;
    end else begin
      ldok_a_ff <= nxt_ldok_a;
      if (wr_en_a) begin
        ldok_a_armed_ff <= 1'b0;
      end else if (rd && sel_en_a && !ldok_a_ff) begin
        ldok_a_armed_ff <= 1'b1;
      end
      if (wr_en_a) begin
        en_a_ff <= pwdata[ptab_pkg::GEN_ENABLE_BIT];
        irqen_a_ff <= pwdata[ptab_pkg::IRQ_ENABLE_BIT];
      end
      if (wr && sel_dead && !wprot_ff) begin
        dead_ff <= pwdata[11:0];
      end
      if (wr && sel_cfg) begin
        mode_ff <= pwdata[ptab_pkg::MODE_BIT];
        center_ff <= pwdata[ptab_pkg::CENTER_BIT];
        wprot_ff <= wprot_ff | pwdata[ptab_pkg::WPROT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // enable control b
  // ----------------------------------------------------------------
  wire logic wr_en_b = wr && sel_en_b && mode_ff;

  always_comb begin
    nxt_ldok_b = ldok_b_ff;
    if (loaded_b) begin
      nxt_ldok_b = 1'b0;
    end
    if (wr_en_b) begin
      if (!pwdata[ptab_pkg::LOAD_OK_BIT]) begin
        nxt_ldok_b = 1'b0;
      end else if (ldok_b_armed_ff || ldok_b_ff) begin
        nxt_ldok_b = 1'b1;
      end
    end
    if (!mode_ff) begin
      nxt_ldok_b = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_b_ff <= 1'b0;
      ldok_b_ff <= 1'b0;
      ldok_b_armed_ff <= 1'b0;
      irqen_b_ff <= 1'b0;
    end else begin
      ldok_b_ff <= nxt_ldok_b;
      if (wr_en_b || !mode_ff) begin
        ldok_b_armed_ff <= 1'b0;
      end else if (rd && sel_en_b && !ldok_b_ff) begin
        ldok_b_armed_ff <= 1'b1;
      end
      if (!mode_ff) begin
        en_b_ff <= 1'b0;
        irqen_b_ff <= 1'b0;
      end else if (wr_en_b) begin
        en_b_ff <= pwdata[ptab_pkg::GEN_ENABLE_BIT];
        irqen_b_ff <= pwdata[ptab_pkg::IRQ_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // requests and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
      dead_out_ff <= 15'h0000;
    end else begin
      irq_a_ff <= nxt_flag_a && irqen_a_ff;
      irq_b_ff <= reload_flag_b && irqen_b_ff && mode_ff;
      dead_out_ff <= dead_cycles(div_act_ff, dead_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign generator_b_enable = en_b_ff;
  assign load_ok_b = ldok_b_ff;
  assign irq_b = irq_b_ff;
  assign generator_a_enable = en_a_ff;
  assign load_ok_a = ldok_a_ff;
  assign pwm_tick_a = tick_ff;
  assign reload_a = reload_ff;
  assign counter_a = cnt_ff;
  assign period_a_active = period_act_ff;
  assign divider_sel_a_active = div_act_ff;
  assign dead_bus_cycles_a = dead_out_ff;
  assign irq_a = irq_a_ff;

endmodule : ptab_timebase
`default_nettype wire

// ---- src/ptab_pkg.sv ----
`default_nettype none
package ptab_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_ENABLE_A = 6'h20;
  localparam logic [5:0] IDX_FREQ_A = 6'h21;
  localparam logic [5:0] IDX_COUNTER_A = 6'h22;
  localparam logic [5:0] IDX_PERIOD_A = 6'h24;
  localparam logic [5:0] IDX_DEAD_A = 6'h26;
  localparam logic [5:0] IDX_ENABLE_B = 6'h28;
  localparam logic [5:0] IDX_CONFIG = 6'h3f;
  // field positions
  localparam int RELOAD_INTERVAL_LSB = 4;
  localparam int HALF_RELOAD_BIT = 3;
  localparam int DIVIDER_SEL_LSB = 1;
  localparam int RELOAD_FLAG_BIT = 0;
  localparam int GEN_ENABLE_BIT = 7;
  localparam int LOAD_OK_BIT = 1;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam int CENTER_BIT = 1;
  localparam int WPROT_BIT = 2;
  // widths and reset values
  localparam int CNT_W = 15;
  localparam int DT_W = 12;
  localparam logic [11:0] DEAD_TIME_RST = 12'hfff;
  localparam logic [14:0] PERIOD_RST = 15'h0001;
  localparam logic [3:0] INTERVAL_RST = 4'h0;
  localparam logic [1:0] DIVIDER_RST = 2'h0;

  typedef enum logic {
    PTAB_UP = 1'b0,
    PTAB_DOWN = 1'b1
  } ptab_dir_t;
endpackage : ptab_pkg
`default_nettype wire

// ---- verif/ptab_timebase_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptab_timebase_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // generator b
  input wire logic reload_flag_b,
  input wire logic irq_b,
  // timebase a
  input wire logic generator_a_enable,
  input wire logic pwm_tick_a,
  input wire logic reload_a,
  input wire logic [14:0] counter_a,
  input wire logic [14:0] period_a_active,
  input wire logic [1:0] divider_sel_a_active,
  input wire logic [14:0] dead_bus_cycles_a
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside an access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reload_tick: assert property (reload_a |-> pwm_tick_a)
    else $error("reload off a pwm tick");
  a_tick_div2: assert property (pwm_tick_a && !reload_a && divider_sel_a_active == 2'h1
    |=> !pwm_tick_a)
    else $error("ticks too close for divide by two");
  a_period_load: assert property ($changed(period_a_active) |-> ##[0:1] reload_a)
    else $error("period changed away from reload");
  a_divider_load: assert property ($changed(divider_sel_a_active) |-> ##[0:1] reload_a)
    else $error("divider changed away from reload");
  a_dead_div1: assert property (divider_sel_a_active == 2'h0
    && $stable(divider_sel_a_active) |-> dead_bus_cycles_a[14:12] == 3'h0)
    else $error("dead time too wide for divide by one");
  a_dead_odd: assert property (divider_sel_a_active != 2'h0
    && $stable(divider_sel_a_active) |-> dead_bus_cycles_a[0])
    else $error("dead time not divisor times value minus one");
  a_irq_b_cause: assert property (irq_b |-> $past(reload_flag_b))
    else $error("irq b without flag");
  a_irq_b_drop: assert property (!reload_flag_b |=> !irq_b)
    else $error("irq b stays after flag drop");
  a_count_hold: assert property (!generator_a_enable
    && $past(!generator_a_enable) |-> $stable(counter_a))
    else $error("counter moves while disabled");
endmodule : ptab_timebase_monitor
bind ptab_timebase ptab_timebase_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .reload_flag_b, .irq_b, .generator_a_enable, .pwm_tick_a, .reload_a, .counter_a,
  .period_a_active, .divider_sel_a_active, .dead_bus_cycles_a);
`default_nettype wire

// ---- verif/ptab_gen_b_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ptab_gen_b_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the block
  input wire logic generator_b_enable,
  input wire logic load_ok_b,
  // bench control
  input wire logic flag_req,
  // to the block
  output logic reload_flag_b,
  output logic loaded_b
);
  logic [3:0] cnt_ff;
  logic loaded_ff;
  logic flag_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      loaded_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff <= generator_b_enable ? cnt_ff + 4'h1 : 4'h0;
      loaded_ff <= generator_b_enable && load_ok_b && (cnt_ff == 4'hf);
      flag_ff <= flag_req;
    end
  end
  assign reload_flag_b = flag_ff;
  assign loaded_b = loaded_ff;
endmodule : ptab_gen_b_model
`default_nettype wire

// ---- verif/pwm_timebase_a_and_enable_b_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module pwm_timebase_a_and_enable_b_tb;
  logic pclk, presetn, psel, penable, pwrite, flag_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, reload_flag_b, loaded_b, generator_b_enable, load_ok_b, irq_b;
  logic generator_a_enable, load_ok_a, pwm_tick_a, reload_a, irq_a;
  logic [14:0] counter_a, period_a_active, dead_bus_cycles_a;
  logic [1:0] divider_sel_a_active;
  logic [64:0] exp_q[$];
  logic [64:0] cur;
  int errors, check_count, g;
  logic [31:0] v;

  ptab_timebase u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reload_flag_b, .loaded_b, .generator_b_enable, .load_ok_b, .irq_b,
    .generator_a_enable, .load_ok_a, .pwm_tick_a, .reload_a, .counter_a, .period_a_active,
    .divider_sel_a_active, .dead_bus_cycles_a, .irq_a);
  ptab_gen_b_model u_gen_b (.pclk, .presetn, .generator_b_enable, .load_ok_b, .flag_req,
    .reload_flag_b, .loaded_b);

  always #50 pclk = ~pclk;

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      cur = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, cur[64]});
      chk(prdata & cur[63:32], cur[31:0] & cur[63:32]);
    end
  end

  task stop_test;
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // bus and timing helpers
  // ----------------------------------------
  // mask m selects compared read bits, e is the expected error response
  task apb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [31:0] m,
           input logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    exp_q.push_back({e, m, d});
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_reload(output int gap);
    gap = 0;
    do begin
      @(posedge pclk);
      gap++;
    end while (reload_a !== 1'b1);
  endtask : wait_reload

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    stop_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, flag_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(57));
    apb(1'b0, ptab_pkg::IDX_DEAD_A, 32'hfff, 32'hfff, 1'b0);
    apb(1'b0, ptab_pkg::IDX_FREQ_A, 32'h0, 32'hff, 1'b0);
    apb(1'b0, 6'h30, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, ptab_pkg::IDX_COUNTER_A, 32'h1234, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_COUNTER_A, 32'h0, 32'h7fff, 1'b0);
    apb(1'b1, ptab_pkg::IDX_DEAD_A, 32'h5, 32'h0, 1'b0);
    apb(1'b1, ptab_pkg::IDX_PERIOD_A, 32'ha, 32'h0, 1'b0);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'h0a, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_ENABLE_A, 32'h0, 32'h82, 1'b0);
    apb(1'b1, ptab_pkg::IDX_ENABLE_A, 32'h83, 32'h0, 1'b0);
    wait_reload(g);
    repeat (2) @(posedge pclk);
    chk(divider_sel_a_active, 32'h1);
    chk(period_a_active, 32'ha);
    chk(load_ok_a, 32'h0);
    chk(dead_bus_cycles_a, 32'h9);
    chk(irq_a, 32'h1);
    wait_reload(g);
    wait_reload(g);
    chk(g, 32'd20);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'hf2, 32'h0, 1'b0);
    wait_reload(g);
    wait_reload(g);
    chk(g, 32'd320);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'hf3, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_FREQ_A, 32'hf3, 32'hff, 1'b0);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'hf3, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_FREQ_A, 32'hf2, 32'hff, 1'b0);
    repeat (2) @(posedge pclk);
    chk(irq_a, 32'h0);
    apb(1'b1, ptab_pkg::IDX_CONFIG, 32'h04, 32'h0, 1'b0);
    apb(1'b1, ptab_pkg::IDX_DEAD_A, 32'h7, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_DEAD_A, 32'h5, 32'hfff, 1'b0);
    apb(1'b1, ptab_pkg::IDX_ENABLE_B, 32'h83, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_ENABLE_B, 32'h0, 32'h83, 1'b0);
    chk(generator_b_enable, 32'h0);
    apb(1'b1, ptab_pkg::IDX_CONFIG, 32'h05, 32'h0, 1'b0);
    apb(1'b0, ptab_pkg::IDX_ENABLE_B, 32'h0, 32'h83, 1'b0);
    apb(1'b1, ptab_pkg::IDX_ENABLE_B, 32'h02, 32'h0, 1'b0);
    @(posedge pclk);
    chk(load_ok_b, 32'h1);
    apb(1'b1, ptab_pkg::IDX_ENABLE_B, 32'h83, 32'h0, 1'b0);
    @(posedge pclk);
    chk(generator_b_enable, 32'h1);
    repeat (20) @(posedge pclk);
    chk(load_ok_b, 32'h0);
    flag_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq_b, 32'h1);
    apb(1'b1, ptab_pkg::IDX_ENABLE_B, 32'h80, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk(irq_b, 32'h0);
    flag_req <= 1'b0;
    apb(1'b1, ptab_pkg::IDX_ENABLE_A, 32'h82, 32'h0, 1'b0);
    apb(1'b1, ptab_pkg::IDX_CONFIG, 32'h07, 32'h0, 1'b0);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'h02, 32'h0, 1'b0);
    wait_reload(g);
    wait_reload(g);
    chk(g, 32'd40);
    chk(counter_a, 32'h0);
    chk(irq_a, 32'h0);
    apb(1'b1, ptab_pkg::IDX_FREQ_A, 32'h0a, 32'h0, 1'b0);
    wait_reload(g);
    wait_reload(g);
    chk(g, 32'd20);
    for (int i = 0; i < 3; i++) begin
      v = $urandom_range(32767, 1);
      apb(1'b1, ptab_pkg::IDX_PERIOD_A, v, 32'h0, 1'b0);
      apb(1'b0, ptab_pkg::IDX_PERIOD_A, v, 32'h7fff, 1'b0);
    end
    stop_test();
  end
endmodule : pwm_timebase_a_and_enable_b_tb
`default_nettype wire
